// [design/hbms_pkg.sv]
// Shared constants, types and state layout for the host bus mode select port.
// Assumes one core clock at 250 MHz and an APB master on the same clock.
package hbms_pkg;

  // ****************************************
  // Host bus geometry
  // ****************************************
  localparam int HB_DATA_W = 16;
  localparam int HB_ADDR_W = 4;
  localparam int HB_WORDS  = 16;

  // ****************************************
  // APB map
  // ****************************************
  localparam logic [11:0] REG_CTRL_OFS    = 12'h000;
  localparam logic [11:0] REG_STATUS_OFS  = 12'h004;
  localparam logic [11:0] REG_HACC_OFS    = 12'h008;
  localparam logic [11:0] REG_MBOX_OFS    = 12'h040;
  localparam logic [11:0] REG_MBOX_END    = 12'h080;
  localparam int          MBOX_IDX_LSB    = 2;
  localparam int          CTRL_PORT_EN_BIT = 0;
  localparam logic        CTRL_PORT_EN_RST = 1'b1;
  localparam int          STAT_ECS_BIT    = 0;
  localparam int          STAT_STRAP_A_BIT = 1;
  localparam int          STAT_STRAP_B_BIT = 2;
  localparam int          STAT_SYSRDY_BIT = 3;
  localparam int          STAT_SLOW_BIT   = 4;
  localparam int          STAT_FAST_BIT   = 5;
  localparam int          STAT_BUSY_BIT   = 6;

  // ****************************************
  // Straps, clocks, reset
  // ****************************************
  localparam logic STRAP_A_PULL = 1'b1;
  localparam logic STRAP_B_PULL = 1'b0;
  localparam int   CORE_CLK_MHZ    = 250;
  localparam int   EXT_CLK_MIN_MHZ = 20;
  localparam int   EXT_CLK_MAX_MHZ = 76;
  localparam int   PER_CNT_W       = 5;
  localparam logic [PER_CNT_W-1:0] EXT_PER_MIN_CYC = PER_CNT_W'(CORE_CLK_MHZ / EXT_CLK_MAX_MHZ);
  localparam logic [PER_CNT_W-1:0] EXT_PER_MAX_CYC =
    PER_CNT_W'((CORE_CLK_MHZ + EXT_CLK_MIN_MHZ - 1) / EXT_CLK_MIN_MHZ);
  localparam int   SYS_RST_HOLD_DEF = 16420;
  localparam int   RST_CNT_W        = 16;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {MODE_NATIVE_SYNC, MODE_SYNC_CORE, MODE_ASYNC_CORE, MODE_ASYNC_EXT} hbms_mode_t;
  typedef enum logic {HOST_IDLE, HOST_BUSY} hbms_hstate_t;
  typedef enum logic [2:0] {REG_CTRL, REG_STATUS, REG_HACC, REG_MBOX, REG_NONE} hbms_reg_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } hbms_apb_req_t;

  typedef struct packed {
    logic                 cs_n;
    logic                 we_n;
    logic                 bsel_lo_n;
    logic                 bsel_hi_n;
    logic [HB_ADDR_W:1]   addr;
    logic [HB_DATA_W-1:0] data;
  } hbms_hbus_in_t;

  localparam hbms_hbus_in_t HB_IN_IDLE = '{cs_n: 1'b1, we_n: 1'b1, bsel_lo_n: 1'b1, bsel_hi_n: 1'b1,
                                          addr: '0, data: '0};

  typedef struct packed {
    hbms_hstate_t                       hst;
    logic [RST_CNT_W-1:0]               rst_cnt;
    logic                               sys_rdy;
    logic                               strap_a;
    logic                               strap_b;
    logic                               ext_sel;
    logic                               ext_prev;
    logic [PER_CNT_W-1:0]               per_cnt;
    logic                               per_valid;
    logic                               ext_slow;
    logic                               ext_fast;
    logic                               port_en;
    logic [HB_WORDS-1:0][HB_DATA_W-1:0] mem;
    logic [15:0]                        hacc_cnt;
    logic [HB_DATA_W-1:0]               dout;
    logic                               doe;
    logic                               pready;
    logic                               pslverr;
    logic [31:0]                        prdata;
  } hbms_state_t;

endpackage

// [design/hbms_sync.sv]
// Two-flop synchroniser for a vector of pin inputs.
// Assumes each bit is a level from outside the core clock domain.
`timescale 1ns/10ps
`default_nettype none
module hbms_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hbms_sync_st_t;

  hbms_sync_st_t st_reg;
  hbms_sync_st_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;

endmodule
`default_nettype wire

// [design/hbms_top.sv]
// Host bus mode select port: strap decode, reset extension, host bus and APB status.
// Assumes host pins arrive asynchronously and an APB master runs on REF_CLK_I.
//
// Behaviour
// [R1] Straps 00 native sync on ext clock, 01 sync on core clock, 10 async on core clock, 11 async on ext clock.
// [R2] An undriven strap takes its pull, high for the first and low for the second, giving async on core clock.
// [R3] Native sync mode runs the host port on the external interface clock and reports ext clock select as 1.
// [R4] The host keeps the external interface clock between 20 MHz and 76 MHz while it is selected.
// [R5] The data bus is 16 bits and the two active-low byte lane selects pick a single byte lane.
// [R6] Data bit 0 is the LSB and address line 1 is the lowest address input, halfword granular.
// [R7] The host selects the port with one of its chip selects, not the boot chip select.
// [R8] The host inserts at least 3 wait states at 64-66 MHz and at least 2 at 56 MHz or below.
// [R9] With both byte lane selects high every access is a full 16-bit access.
// [R10] Internal reset stays asserted about 16420 core clocks after power-on reset and host access waits for it.
// [R11] In native sync mode all host transfers are sampled and driven on external interface clock edges.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module hbms_top
  import hbms_pkg::*;
#(
  parameter int unsigned SYS_RST_HOLD_CYCLES = SYS_RST_HOLD_DEF
) (
  input  wire logic                 REF_CLK_I,
  input  wire logic                 RST_N_I,
  input  wire logic                 PSEL_I,
  input  wire logic                 PENABLE_I,
  input  wire logic                 PWRITE_I,
  input  wire logic [11:0]          PADDR_I,
  input  wire logic [31:0]          PWDATA_I,
  output logic      [31:0]          PRDATA_O,
  output logic                      PREADY_O,
  output logic                      PSLVERR_O,
  input  wire logic                 EXT_HOST_IFACE_CLK_I,
  input  wire logic                 IFACE_STRAP_A_I,
  input  wire logic                 IFACE_STRAP_B_I,
  input  wire logic                 IFACE_STRAP_A_FLOAT_I,
  input  wire logic                 IFACE_STRAP_B_FLOAT_I,
  input  wire logic                 HOST_CS_N_I,
  input  wire logic                 HOST_WE_N_I,
  input  wire logic                 BYTE_LANE_SEL_LO_N_I,
  input  wire logic                 BYTE_LANE_SEL_HI_N_I,
  input  wire logic [HB_ADDR_W:1]   HOST_ADDR_I,
  input  wire logic [HB_DATA_W-1:0] HOST_DATA_I,
  output logic      [HB_DATA_W-1:0] HOST_DATA_O,
  output logic                      HOST_DATA_OE_O,
  output logic                      EXT_CLK_SELECT_STATUS_O,
  output logic                      SYS_RDY_O
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic hbms_mode_t decode_mode(input logic a, input logic b);
    hbms_mode_t m;
    m = MODE_NATIVE_SYNC;
    if (!a && b) begin
      m = MODE_SYNC_CORE;
    end else if (a && !b) begin
      m = MODE_ASYNC_CORE;
    end else if (a && b) begin
      m = MODE_ASYNC_EXT;
    end
    return m;
  endfunction

  function automatic logic mode_uses_ext(input hbms_mode_t m);
    return (m == MODE_NATIVE_SYNC) || (m == MODE_ASYNC_EXT);
  endfunction

  function automatic hbms_reg_t reg_decode(input logic [11:0] a);
    hbms_reg_t r;
    r = REG_NONE;
    if (a == REG_CTRL_OFS) begin
      r = REG_CTRL;
    end else if (a == REG_STATUS_OFS) begin
      r = REG_STATUS;
    end else if (a == REG_HACC_OFS) begin
      r = REG_HACC;
    end else if (a >= REG_MBOX_OFS && a < REG_MBOX_END && a[MBOX_IDX_LSB-1:0] == '0) begin
      r = REG_MBOX;
    end
    return r;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int          MISC_W    = 5;
  localparam int          SYNC_W    = $bits(hbms_hbus_in_t) + MISC_W;
  localparam logic [MISC_W-1:0] MISC_IDLE = '0;
  localparam logic [RST_CNT_W-1:0] HOLD_LAST = RST_CNT_W'(SYS_RST_HOLD_CYCLES - 1);
  localparam logic [RST_CNT_W-1:0] HOLD_CNT  = RST_CNT_W'(SYS_RST_HOLD_CYCLES);
  localparam logic [PER_CNT_W-1:0] PER_SAT   = '1;

  hbms_hbus_in_t      hb_pins;
  hbms_hbus_in_t      s_hb;
  logic [SYNC_W-1:0]  sync_q;
  logic               s_ext;
  logic               s_strap_a;
  logic               s_strap_b;
  logic               s_float_a;
  logic               s_float_b;
  hbms_apb_req_t      apb;
  hbms_state_t        st_reg;
  hbms_state_t        st_next;
  logic               strap_a_res;
  logic               strap_b_res;
  logic               ext_rise;
  logic               tick;
  logic               hwr;
  logic               hrd;
  logic               apb_wr;
  logic [HB_ADDR_W-1:0] haddr;
  logic [HB_ADDR_W-1:0] midx;
  logic [HB_DATA_W-1:0] old_word;
  logic [1:0]         lanes;
  hbms_reg_t          rsel_setup;
  hbms_reg_t          rsel_acc;
  logic [31:0]        stat_word;

  assign hb_pins = '{cs_n: HOST_CS_N_I, we_n: HOST_WE_N_I, bsel_lo_n: BYTE_LANE_SEL_LO_N_I,
                     bsel_hi_n: BYTE_LANE_SEL_HI_N_I, addr: HOST_ADDR_I, data: HOST_DATA_I};

  hbms_sync #(
    .W       (SYNC_W),
    .RST_VAL ({MISC_IDLE, HB_IN_IDLE})
  ) u_sync (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     ({EXT_HOST_IFACE_CLK_I, IFACE_STRAP_A_I, IFACE_STRAP_B_I,
               IFACE_STRAP_A_FLOAT_I, IFACE_STRAP_B_FLOAT_I, hb_pins}),
    .q_o     (sync_q)
  );

  assign {s_ext, s_strap_a, s_strap_b, s_float_a, s_float_b, s_hb} = sync_q;
  assign apb = '{psel: PSEL_I, penable: PENABLE_I, pwrite: PWRITE_I, paddr: PADDR_I, pwdata: PWDATA_I};

  // ****************************************
  // Request qualifiers
  // ****************************************
  assign strap_a_res = s_float_a ? STRAP_A_PULL : s_strap_a; // [R2]
  assign strap_b_res = s_float_b ? STRAP_B_PULL : s_strap_b; // [R2]
  assign ext_rise    = s_ext && !st_reg.ext_prev;
  assign tick        = st_reg.ext_sel ? ext_rise : 1'b1; // [R11]
  assign hwr = st_reg.sys_rdy && st_reg.port_en && tick && st_reg.hst == HOST_IDLE && !s_hb.cs_n && !s_hb.we_n;
  assign hrd = st_reg.sys_rdy && st_reg.port_en && tick && st_reg.hst == HOST_IDLE && !s_hb.cs_n && s_hb.we_n; // [R10]
  assign haddr    = s_hb.addr; // [R6]
  assign old_word = st_reg.mem[haddr];
  assign lanes    = (s_hb.bsel_lo_n ^ s_hb.bsel_hi_n) ? {!s_hb.bsel_hi_n, !s_hb.bsel_lo_n} : 2'h3; // [R5] [R9]
  assign midx     = apb.paddr[MBOX_IDX_LSB +: HB_ADDR_W];
  assign rsel_setup = reg_decode(apb.paddr);
  assign rsel_acc   = reg_decode(apb.paddr);
  assign apb_wr     = apb.psel && apb.penable && st_reg.pready && apb.pwrite;

  always_comb begin
    stat_word                   = '0;
    stat_word[STAT_ECS_BIT]     = st_reg.ext_sel;
    stat_word[STAT_STRAP_A_BIT] = st_reg.strap_a;
    stat_word[STAT_STRAP_B_BIT] = st_reg.strap_b;
    stat_word[STAT_SYSRDY_BIT]  = st_reg.sys_rdy;
    stat_word[STAT_SLOW_BIT]    = st_reg.ext_slow;
    stat_word[STAT_FAST_BIT]    = st_reg.ext_fast;
    stat_word[STAT_BUSY_BIT]    = st_reg.hst == HOST_BUSY;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next         = st_reg;
    st_next.pready  = 1'b0;
    st_next.pslverr = 1'b0;
    // APB setup: answer next cycle
    if (apb.psel && !apb.penable) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = rsel_setup == REG_NONE;
      st_next.prdata  = '0;
      if (rsel_setup == REG_CTRL) begin
        st_next.prdata[CTRL_PORT_EN_BIT] = st_reg.port_en;
      end else if (rsel_setup == REG_STATUS) begin
        st_next.prdata = stat_word;
      end else if (rsel_setup == REG_HACC) begin
        st_next.prdata[15:0] = st_reg.hacc_cnt;
      end else if (rsel_setup == REG_MBOX) begin
        st_next.prdata[HB_DATA_W-1:0] = st_reg.mem[midx];
      end
    end
    // APB write at the completing edge
    if (apb_wr) begin
      if (rsel_acc == REG_CTRL) begin
        st_next.port_en = apb.pwdata[CTRL_PORT_EN_BIT];
      end else if (rsel_acc == REG_STATUS) begin
        if (apb.pwdata[STAT_SLOW_BIT]) begin
          st_next.ext_slow = 1'b0;
        end
        if (apb.pwdata[STAT_FAST_BIT]) begin
          st_next.ext_fast = 1'b0;
        end
      end else if (rsel_acc == REG_MBOX) begin
        st_next.mem[midx] = apb.pwdata[HB_DATA_W-1:0];
      end
    end
    // Reset extension and strap capture
    if (!st_reg.sys_rdy) begin
      st_next.strap_a = strap_a_res;
      st_next.strap_b = strap_b_res;
      st_next.ext_sel = mode_uses_ext(decode_mode(strap_a_res, strap_b_res)); // [R1] [R3]
      if (st_reg.rst_cnt == HOLD_LAST) begin
        st_next.sys_rdy = 1'b1; // [R10]
      end else begin
        st_next.rst_cnt = st_reg.rst_cnt + 16'h1;
      end
    end
    // Ext clock period monitor, set wins over clear
    st_next.ext_prev = s_ext;
    if (st_reg.ext_sel && ext_rise) begin
      if (st_reg.per_valid && st_reg.per_cnt < EXT_PER_MIN_CYC) begin
        st_next.ext_fast = 1'b1; // [R4]
      end
      st_next.per_cnt   = 5'h1;
      st_next.per_valid = 1'b1;
    end else if (st_reg.ext_sel && st_reg.per_cnt != PER_SAT) begin
      st_next.per_cnt = st_reg.per_cnt + 5'h1;
    end
    if (st_reg.per_valid && st_reg.per_cnt > EXT_PER_MAX_CYC) begin
      st_next.ext_slow = 1'b1; // [R4]
    end
    // Host bus access
    case (st_reg.hst)
      HOST_IDLE: begin
        if (hwr || hrd) begin
          st_next.hst      = HOST_BUSY;
          st_next.hacc_cnt = st_reg.hacc_cnt + 16'h1;
          if (hwr) begin
            if (lanes[0]) begin
              st_next.mem[haddr][7:0] = s_hb.data[7:0]; // [R5]
            end
            if (lanes[1]) begin
              st_next.mem[haddr][15:8] = s_hb.data[15:8]; // [R5]
            end
          end else begin
            st_next.dout = old_word; // [R11]
            st_next.doe  = 1'b1;
          end
        end
      end
      HOST_BUSY: begin
        if (tick && s_hb.cs_n) begin
          st_next.hst = HOST_IDLE; // [R11]
          st_next.doe = 1'b0;
        end
      end
      default: begin
        st_next.hst = HOST_IDLE;
      end
    endcase
  end

  localparam hbms_state_t ST_RESET = '{hst: HOST_IDLE, port_en: CTRL_PORT_EN_RST, default: '0};

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign PRDATA_O                = st_reg.prdata;
  assign PREADY_O                = st_reg.pready;
  assign PSLVERR_O               = st_reg.pslverr;
  assign HOST_DATA_O             = st_reg.dout;
  assign HOST_DATA_OE_O          = st_reg.doe;
  assign EXT_CLK_SELECT_STATUS_O = st_reg.ext_sel;
  assign SYS_RDY_O               = st_reg.sys_rdy;

  // ****************************************
  // Checks
  // ****************************************
  logic [RST_CNT_W-1:0] rel_cnt;

  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      rel_cnt <= '0;
    end else if (rel_cnt != HOLD_CNT) begin
      rel_cnt <= rel_cnt + 16'h1;
    end
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_strap_mode_decode: assert property ( // [R1]
    st_reg.sys_rdy |-> st_reg.ext_sel == (st_reg.strap_a == st_reg.strap_b))
    else $error("ext clock select does not match strap decode");
  a_strap_pull_default: assert property ( // [R2]
    (!st_reg.sys_rdy && s_float_a && s_float_b) |=> (st_reg.strap_a && !st_reg.strap_b && !st_reg.ext_sel))
    else $error("floating straps did not give async core clock mode");
  a_native_ecs_one: assert property ( // [R3]
    (st_reg.sys_rdy && !st_reg.strap_a && !st_reg.strap_b) |-> EXT_CLK_SELECT_STATUS_O)
    else $error("native sync mode without ext clock select");
  a_byte_lane_keep: assert property ( // [R5]
    (hwr && !s_hb.bsel_lo_n && s_hb.bsel_hi_n && !apb_wr)
      |=> st_reg.mem[$past(haddr)] == {$past(old_word[15:8]), $past(s_hb.data[7:0])})
    else $error("low byte write touched the high lane");

  a_read_addr_map: assert property ( // [R6]
    hrd |=> (HOST_DATA_OE_O && HOST_DATA_O == $past(old_word)) ##1 HOST_DATA_OE_O)
    else $error("host read returned wrong word or dropped drive");

  a_full_width_write: assert property ( // [R9]
    (hwr && s_hb.bsel_lo_n && s_hb.bsel_hi_n && !apb_wr) |=> st_reg.mem[$past(haddr)] == $past(s_hb.data))
    else $error("full width write not stored");
  a_sys_reset_hold: assert property ( // [R10]
    st_reg.sys_rdy == (rel_cnt == HOLD_CNT))
    else $error("internal reset released at the wrong cycle");

  a_no_host_in_reset: assert property ( // [R10]
    !st_reg.sys_rdy |-> (!HOST_DATA_OE_O && st_reg.hacc_cnt == '0 && st_reg.hst == HOST_IDLE))
    else $error("host access taken during internal reset");

  a_ext_edge_only: assert property ( // [R11]
    (st_reg.ext_sel && $changed(st_reg.hacc_cnt)) |-> $past(ext_rise))
    else $error("native mode access not on ext clock edge");

  a_apb_answer: assert property (
    (apb.psel && !apb.penable) |=> PREADY_O ##1 !PREADY_O)
    else $error("APB answer not one cycle after setup");

  c_native_write: cover property (st_reg.ext_sel && hwr);
  c_byte_write:   cover property (hwr && !s_hb.bsel_hi_n && s_hb.bsel_lo_n);
  c_host_read:    cover property (hrd ##1 HOST_DATA_OE_O);
  c_sys_ready:    cover property ($rose(st_reg.sys_rdy));

endmodule
`default_nettype wire

// [testbench/hbms_host_model.sv]
// Host bus master model: one chip select, wait states, free-running interface clock.
// Assumes bus_o is wired to the host pins of the port and clk_i is the core clock.
`timescale 1ns/10ps
`default_nettype none
module hbms_host_model
  import hbms_pkg::*;
#(
  parameter real EXT_HALF_NS = 80.0
) (
  input  wire logic        clk_i,
  output var  logic        ext_clk_o,
  output var  hbms_hbus_in_t bus_o
);
  // ****************************************
  // Interface clock
  // ****************************************
  initial begin
    ext_clk_o = 1'b0;
    bus_o = HB_IN_IDLE;
    #37.5;
    forever #(EXT_HALF_NS) ext_clk_o = ~ext_clk_o;
  end

  // ****************************************
  // One access
  // ****************************************
  task automatic access(input logic wr, input logic [1:0] lanes_n, input logic [HB_ADDR_W:1] a,
                        input logic [HB_DATA_W-1:0] d);
    hbms_hbus_in_t b;
    b = '{cs_n: 1'b0, we_n: ~wr, bsel_lo_n: lanes_n[0], bsel_hi_n: lanes_n[1], addr: a,
          data: wr ? d : ~bus_o.data};
    @(posedge ext_clk_o);
    @(posedge clk_i);
    bus_o <= b;
    repeat (4) @(posedge ext_clk_o);
    @(posedge clk_i);
    bus_o <= '{cs_n: 1'b1, we_n: 1'b1, bsel_lo_n: 1'b1, bsel_hi_n: 1'b1, addr: ~a, data: ~b.data};
    repeat (2) @(posedge ext_clk_o);
  endtask
endmodule
`default_nettype wire

// [testbench/host_bus_mode_select_port_bench.sv]
// Self-checking bench: straps, reset extension, APB map, host bus traffic.
// Assumes the host model drives the host pins and the bench is the APB master.
`timescale 1ns/10ps
`default_nettype none
module host_bus_mode_select_port_bench import hbms_pkg::*;;
  localparam int HOLD = 20;
  typedef struct packed {logic err; logic [31:0] mask; logic [31:0] data;} hbms_exp_t;
  logic                 REF_CLK_I;
  logic                 RST_N_I;
  hbms_apb_req_t        apb;
  logic [31:0]          PRDATA_O;
  logic                 PREADY_O, PSLVERR_O, ext_clk, HOST_DATA_OE_O, EXT_CLK_SELECT_STATUS_O, SYS_RDY_O, oe_d;
  logic [3:0]           strap;
  hbms_hbus_in_t        host;
  logic [HB_DATA_W-1:0] HOST_DATA_O, d;
  logic [HB_DATA_W-1:0] mb [HB_WORDS];
  logic                 ea, eb, ecs;
  hbms_exp_t            e;
  hbms_exp_t            apb_q [$];
  logic [HB_DATA_W-1:0] host_q [$];
  int                   n_mismatch, n_tests, n_acc;
  wire logic [HB_DATA_W-1:0] host_wire;
  assign host_wire = HOST_DATA_OE_O ? HOST_DATA_O : host.data;

  hbms_top #(.SYS_RST_HOLD_CYCLES(HOLD)) uut (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(apb.psel), .PENABLE_I(apb.penable),
    .PWRITE_I(apb.pwrite), .PADDR_I(apb.paddr), .PWDATA_I(apb.pwdata), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .EXT_HOST_IFACE_CLK_I(ext_clk),
    .IFACE_STRAP_A_I(strap[0]), .IFACE_STRAP_B_I(strap[1]), .IFACE_STRAP_A_FLOAT_I(strap[2]),
    .IFACE_STRAP_B_FLOAT_I(strap[3]), .HOST_CS_N_I(host.cs_n), .HOST_WE_N_I(host.we_n),
    .BYTE_LANE_SEL_LO_N_I(host.bsel_lo_n), .BYTE_LANE_SEL_HI_N_I(host.bsel_hi_n), .HOST_ADDR_I(host.addr),
    .HOST_DATA_I(host_wire), .HOST_DATA_O(HOST_DATA_O), .HOST_DATA_OE_O(HOST_DATA_OE_O),
    .EXT_CLK_SELECT_STATUS_O(EXT_CLK_SELECT_STATUS_O), .SYS_RDY_O(SYS_RDY_O));
  hbms_host_model u_host (.clk_i(REF_CLK_I), .ext_clk_o(ext_clk), .bus_o(host));

  // ****************************************
  // Clock, checks, closing
  // ****************************************
  initial begin
    REF_CLK_I = 1'b0;
    forever #2 REF_CLK_I = ~REF_CLK_I;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (apb_q.size() != 0 || host_q.size() != 0) n_mismatch++;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge REF_CLK_I) begin
    oe_d <= HOST_DATA_OE_O;
    if (PREADY_O === 1'b1 && apb.penable && apb_q.size() > 0) begin
      e = apb_q.pop_front();
      check(PRDATA_O & e.mask, e.data);
      check({31'h0, PSLVERR_O}, {31'h0, e.err});
    end
    if (HOST_DATA_OE_O === 1'b1 && oe_d !== 1'b1 && host_q.size() > 0)
      check({16'h0, HOST_DATA_O}, {16'h0, host_q.pop_front()});
  end

  // ****************************************
  // Drivers
  // ****************************************
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] mask,
                          input logic [31:0] exp, input logic err);
    apb_q.push_back('{err: err, mask: mask, data: exp & mask});
    @(posedge REF_CLK_I);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge REF_CLK_I);
    apb.penable <= 1'b1;
    do begin
      @(posedge REF_CLK_I);
    end while (PREADY_O !== 1'b1);
    apb <= '0;
  endtask

  task automatic do_reset;
    @(posedge REF_CLK_I);
    RST_N_I <= 1'b0;
    repeat (3) @(posedge REF_CLK_I);
    RST_N_I <= 1'b1;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    results();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    RST_N_I = 1'b0;
    apb = '0;
    strap = 4'b1100;
    n_mismatch = 0;
    n_tests = 0;
    n_acc = 0;
    void'($urandom(19813));
    repeat (3) @(posedge REF_CLK_I);
    check({31'h0, SYS_RDY_O}, 32'h0);
    check({31'h0, HOST_DATA_OE_O}, 32'h0);
    RST_N_I <= 1'b1;
    repeat (HOLD - 3) @(posedge REF_CLK_I);
    check({31'h0, SYS_RDY_O}, 32'h0);
    repeat (6) @(posedge REF_CLK_I);
    check({31'h0, SYS_RDY_O}, 32'h1);
    $display("test reset_hold done");
    for (int i = 4; i >= 0; i--) begin
      strap <= (i == 4) ? 4'b1110 : {2'b00, i[0], i[1]};
      ea = (i == 4) ? 1'b1 : i[1];
      eb = (i == 4) ? 1'b0 : i[0];
      ecs = (ea == eb);
      do_reset();
      repeat (150) @(posedge REF_CLK_I);
      check({31'h0, EXT_CLK_SELECT_STATUS_O}, {31'h0, ecs});
      apb_xfer(1'b0, REG_STATUS_OFS, 32'h0, 32'h3f, (32'(ecs) << STAT_ECS_BIT) | (32'(ea) << STAT_STRAP_A_BIT) |
               (32'(eb) << STAT_STRAP_B_BIT) | (32'(ecs) << STAT_SLOW_BIT) | (32'h1 << STAT_SYSRDY_BIT),
               1'b0);
    end
    $display("test strap_modes done");
    apb_xfer(1'b0, REG_CTRL_OFS, 32'h0, 32'h1, 32'(CTRL_PORT_EN_RST), 1'b0);
    apb_xfer(1'b0, 12'h100, 32'h0, 32'hffffffff, 32'h0, 1'b1);
    apb_xfer(1'b1, 12'h042, 32'h1234, 32'h0, 32'h0, 1'b1);
    $display("test apb_map done");
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom);
      u_host.access(1'b1, 2'b11, HB_ADDR_W'(i), d);
      mb[i] = d;
      d = 16'($urandom);
      u_host.access(1'b1, i[1:0], HB_ADDR_W'(i), d);
      mb[i] = {(i[1:0] == 2'b10) ? mb[i][15:8] : d[15:8], (i[1:0] == 2'b01) ? mb[i][7:0] : d[7:0]};
      n_acc += 2;
      apb_xfer(1'b0, REG_MBOX_OFS + 12'(4 * i), 32'h0, 32'hffffffff, {16'h0, mb[i]}, 1'b0);
    end
    host_q.push_back(mb[1]);
    u_host.access(1'b0, 2'b11, 4'h1, 16'h0);
    d = 16'($urandom);
    apb_xfer(1'b1, REG_MBOX_OFS + 12'h014, {16'h0, d}, 32'h0, 32'h0, 1'b0);
    host_q.push_back(d);
    u_host.access(1'b0, 2'b11, 4'h5, 16'h0);
    n_acc += 2;
    $display("test host_traffic done");
    apb_xfer(1'b1, REG_CTRL_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
    u_host.access(1'b1, 2'b11, 4'h2, ~mb[2]);
    apb_xfer(1'b0, REG_MBOX_OFS + 12'h008, 32'h0, 32'hffffffff, {16'h0, mb[2]}, 1'b0);
    apb_xfer(1'b1, REG_CTRL_OFS, 32'h1, 32'h0, 32'h0, 1'b0);
    apb_xfer(1'b0, REG_HACC_OFS, 32'h0, 32'hffff, 32'(n_acc), 1'b0);
    $display("test port_disable done");
    strap <= 4'b0010;
    do_reset();
    repeat (30) @(posedge REF_CLK_I);
    d = 16'($urandom);
    u_host.access(1'b1, 2'b01, 4'h3, d);
    apb_xfer(1'b0, REG_MBOX_OFS + 12'h00c, 32'h0, 32'hffffffff, {16'h0, d[15:8], 8'h00}, 1'b0);
    $display("test core_mode done");
    repeat (2) @(posedge REF_CLK_I);
    results();
  end
endmodule
`default_nettype wire
